//--- rtl/dpds_cfg.svh
// offsets, field positions, reset values and fixed figures of the output clock control block
`ifndef DPDS_CFG_SVH
`define DPDS_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define DPDS_DELAY_FIRST 8'h34
`define DPDS_DELAY_LAST 8'h3A
`define DPDS_RAMP_A 8'h35
`define DPDS_FINE_A 8'h36
`define DPDS_RAMP_B 8'h39
`define DPDS_FINE_B 8'h3A
`define DPDS_OUTCTL_FIRST 8'h3C
`define DPDS_OUTCTL_LAST 8'h43
`define DPDS_DIV_FIRST 8'h48
`define DPDS_PHASE_FIRST 8'h49
`define DPDS_PHASE_LAST 8'h57
`define DPDS_FUNC 8'h58

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DPDS_PH_OFS_MSB 3
`define DPDS_PH_START_BIT 4
`define DPDS_RAMP_CODE_MSB 2
`define DPDS_CAP_MSB 5
`define DPDS_CAP_LSB 3
`define DPDS_FINE_MSB 5
`define DPDS_FINE_LSB 1
`define DPDS_OUT_OFF_BIT 0
`define DPDS_OUT_CMOS_BIT 1
`define DPDS_FUNC_SOFTSYNC_BIT 2
`define DPDS_FUNC_MODE_LSB 5
`define DPDS_FUNC_ASLEEP_BIT 7

// ----------------------------------------------------------------------------
// pin modes, reset values, figures
// ----------------------------------------------------------------------------
`define DPDS_MODE_HRESET 2'h0
`define DPDS_MODE_SYNC 2'h1
`define DPDS_MODE_SLEEP 2'h2
`define DPDS_RST_BYTE 8'h00
`define DPDS_RAMP_STEP_UA 11'h0C8
`define DPDS_START_HIGH_STEP 5'h10

`endif

//--- rtl/dpds_pkg.sv
// types shared by the output clock control block
package dpds_pkg;

  // divide ratio byte: low and high cycles minus one
  typedef struct packed {
    logic [3:0] lo;
    logic [3:0] hi;
  } dpds_div_cfg_s;

  // phase byte: start level and coarse offset
  typedef struct packed {
    logic [2:0] rsvd;
    logic start_high;
    logic [3:0] offset;
  } dpds_phase_s;

  // decoded settings handed to one analog delay path
  typedef struct packed {
    logic [10:0] ramp_ua;
    logic [2:0] caps;
    logic [4:0] fine;
  } dpds_delay_s;

  // chip power and sync state
  typedef enum logic [3:0] {
    DPDS_RUN = 4'h1,
    DPDS_SYNC = 4'h2,
    DPDS_SLEEP = 4'h4,
    DPDS_HRESET = 4'h8
  } dpds_state_e;

endpackage : dpds_pkg

//--- rtl/dpds_divider.sv
// one output divider with coarse phase offset and start level
`timescale 1ns/1ps
`include "dpds_cfg.svh"
module dpds_divider (
  input wire logic clock,
  input wire logic resetn,
  input wire logic halt,
  input wire logic sync_hold,
  input wire dpds_pkg::dpds_div_cfg_s div_cfg,
  input wire dpds_pkg::dpds_phase_s phase,
  output logic clk_out
);

  logic [4:0] cnt_q;
  logic out_q;
  logic [4:0] delay;

  // 32 delay states: offset alone, or offset plus 16 with start high
  assign delay = {1'b0, phase.offset} + (phase.start_high ? `DPDS_START_HIGH_STEP : 5'h00);

  // counter cleared while halted and preloaded with the delay while sync holds, counting fast edges after release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 5'h00;
      out_q <= 1'b0;
    end else if (halt) begin
      cnt_q <= 5'h00;
      out_q <= 1'b0;
    end else if (sync_hold) begin
      cnt_q <= delay;
      out_q <= phase.start_high;
    end else if (cnt_q == 5'h00) begin
      // whole fast periods only, so an offset equal to the ratio repeats phase zero
      out_q <= ~out_q;
      cnt_q <= out_q ? {1'b0, div_cfg.lo} : {1'b0, div_cfg.hi};
    end else begin
      cnt_q <= cnt_q - 5'h01;
    end
  end

  assign clk_out = out_q;

endmodule : dpds_divider

//--- rtl/dpds_delay_calc.sv
// decodes the ramp and fine adjust bytes of one delay path
`timescale 1ns/1ps
`include "dpds_cfg.svh"
module dpds_delay_calc (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] ramp_byte,
  input wire logic [7:0] fine_byte,
  output dpds_pkg::dpds_delay_s settings
);

  // capacitors in use: one per zero bit of the field, plus one
  function automatic logic [2:0] cap_count(input logic [2:0] f);
    cap_count = 3'h1 + {2'h0, ~f[0]} + {2'h0, ~f[1]} + {2'h0, ~f[2]};
  endfunction : cap_count

  logic [10:0] ramp_ua;
  assign ramp_ua = 11'(`DPDS_RAMP_STEP_UA * ({8'h00, ramp_byte[`DPDS_RAMP_CODE_MSB:0]} + 11'h001));

  // registered so the analog path sees glitch-free codes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settings <= '0;
    end else begin
      settings.ramp_ua <= ramp_ua;
      settings.caps <= cap_count(ramp_byte[`DPDS_CAP_MSB:`DPDS_CAP_LSB]);
      settings.fine <= fine_byte[`DPDS_FINE_MSB:`DPDS_FINE_LSB];
    end
  end

endmodule : dpds_delay_calc

//--- rtl/dpds_top.sv
// output clock control: dividers, phase, delay settings, output enables and sleep
`timescale 1ns/1ps
`include "dpds_cfg.svh"
module dpds_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic function_pin,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [7:0] clk_out,
  output logic [7:0] out_enable,
  output logic [3:0] out_cmos_sel,
  output logic [3:0] lvpecl_safe_off,
  output logic pll_powerdown,
  output logic asleep,
  output dpds_pkg::dpds_delay_s delayed_output_a_cfg,
  output dpds_pkg::dpds_delay_s delayed_output_b_cfg
);

  // --------------------------------------------------------------------------
  // address decode helpers
  // --------------------------------------------------------------------------

  // odd bytes 49h..57h carry phase, the even byte below each carries the ratio
  function automatic logic is_phase(input logic [7:0] a);
    is_phase = (a >= `DPDS_PHASE_FIRST) && (a <= `DPDS_PHASE_LAST) && a[0];
  endfunction : is_phase

  function automatic logic is_div(input logic [7:0] a);
    is_div = (a >= `DPDS_DIV_FIRST) && (a < `DPDS_PHASE_LAST) && !a[0];
  endfunction : is_div

  function automatic logic is_outctl(input logic [7:0] a);
    is_outctl = (a >= `DPDS_OUTCTL_FIRST) && (a <= `DPDS_OUTCTL_LAST);
  endfunction : is_outctl

  // divider index from a phase or ratio byte address
  function automatic logic [2:0] div_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `DPDS_DIV_FIRST;
    div_index = d[3:1];
  endfunction : div_index

  // output index from an output control byte address
  function automatic logic [2:0] out_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `DPDS_OUTCTL_FIRST;
    out_index = d[2:0];
  endfunction : out_index

  // --------------------------------------------------------------------------
  // function pin synchroniser
  // --------------------------------------------------------------------------

  logic [2:0] pin_sync_q;
  logic pin_low_q;

  // three stages; a change counts only once stages two and three agree
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_sync_q <= 3'h7;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], function_pin};
    end
  end

  // filtered pin level, active high when the pin is held low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_low_q <= 1'b0;
    end else if (pin_sync_q[1] == pin_sync_q[2]) begin
      pin_low_q <= ~pin_sync_q[2];
    end
  end

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------

  dpds_pkg::dpds_div_cfg_s div_cfg_q [0:7];
  dpds_pkg::dpds_phase_s phase_q [0:7];
  logic [7:0] outctl_q [0:7];
  logic [7:0] ramp_a_q;
  logic [7:0] fine_a_q;
  logic [7:0] ramp_b_q;
  logic [7:0] fine_b_q;
  logic [1:0] pin_mode_q;
  logic soft_sync_q;

  dpds_pkg::dpds_state_e state_q;
  dpds_pkg::dpds_state_e state_d;
  logic hard_reset;

  // hard reset acts from the filtered pin so one noisy sample cannot wipe state
  assign hard_reset = pin_low_q && (pin_mode_q == `DPDS_MODE_HRESET);

  // divider ratio and phase bytes; writes land in every power state but hard reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        div_cfg_q[i] <= `DPDS_RST_BYTE;
        phase_q[i] <= `DPDS_RST_BYTE;
      end
    end else if (hard_reset) begin
      for (int i = 0; i < 8; i++) begin
        div_cfg_q[i] <= `DPDS_RST_BYTE;
        phase_q[i] <= `DPDS_RST_BYTE;
      end
    end else if (reg_wr_en && is_phase(reg_addr)) begin
      // upper reserved bits are not stored and read as zero
      phase_q[div_index(reg_addr)] <= {3'h0, reg_wdata[`DPDS_PH_START_BIT:0]};
    end else if (reg_wr_en && is_div(reg_addr)) begin
      div_cfg_q[div_index(reg_addr)] <= reg_wdata;
    end
  end

  // output enable and level bytes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        outctl_q[i] <= `DPDS_RST_BYTE;
      end
    end else if (hard_reset) begin
      for (int i = 0; i < 8; i++) begin
        outctl_q[i] <= `DPDS_RST_BYTE;
      end
    end else if (reg_wr_en && is_outctl(reg_addr)) begin
      // only off and level bits exist; level is meaningless on the LVPECL four
      outctl_q[out_index(reg_addr)] <= {6'h00, reg_wdata[`DPDS_OUT_CMOS_BIT:0]};
    end
  end

  // delay path bytes, kept only for the two delayed outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ramp_a_q <= `DPDS_RST_BYTE;
      fine_a_q <= `DPDS_RST_BYTE;
      ramp_b_q <= `DPDS_RST_BYTE;
      fine_b_q <= `DPDS_RST_BYTE;
    end else if (hard_reset) begin
      ramp_a_q <= `DPDS_RST_BYTE;
      fine_a_q <= `DPDS_RST_BYTE;
      ramp_b_q <= `DPDS_RST_BYTE;
      fine_b_q <= `DPDS_RST_BYTE;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        `DPDS_RAMP_A: ramp_a_q <= {2'h0, reg_wdata[`DPDS_CAP_MSB:0]};
        `DPDS_FINE_A: fine_a_q <= {2'h0, reg_wdata[`DPDS_FINE_MSB:`DPDS_FINE_LSB], 1'b0};
        `DPDS_RAMP_B: ramp_b_q <= {2'h0, reg_wdata[`DPDS_CAP_MSB:0]};
        `DPDS_FINE_B: fine_b_q <= {2'h0, reg_wdata[`DPDS_FINE_MSB:`DPDS_FINE_LSB], 1'b0};
        default: ;
      endcase
    end
  end

  // function pin mode and soft sync
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_mode_q <= `DPDS_MODE_HRESET;
      soft_sync_q <= 1'b0;
    end else if (hard_reset) begin
      pin_mode_q <= `DPDS_MODE_HRESET;
      soft_sync_q <= 1'b0;
    end else if (reg_wr_en && (reg_addr == `DPDS_FUNC)) begin
      pin_mode_q <= reg_wdata[`DPDS_FUNC_MODE_LSB+1:`DPDS_FUNC_MODE_LSB];
      soft_sync_q <= reg_wdata[`DPDS_FUNC_SOFTSYNC_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // power and sync state
  // --------------------------------------------------------------------------

  // sleep outranks sync: sync circuits are off while asleep
  always_comb begin
    state_d = dpds_pkg::DPDS_RUN;
    if (hard_reset) begin
      state_d = dpds_pkg::DPDS_HRESET;
    end else if (pin_low_q && (pin_mode_q == `DPDS_MODE_SLEEP)) begin
      state_d = dpds_pkg::DPDS_SLEEP;
    end else if ((pin_low_q && (pin_mode_q == `DPDS_MODE_SYNC)) || soft_sync_q) begin
      state_d = dpds_pkg::DPDS_SYNC;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= dpds_pkg::DPDS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  logic halt;
  logic sync_hold;

  // waking drops straight to run; phase alignment needs a fresh sync from outside
  always_comb begin
    halt = 1'b0;
    sync_hold = 1'b0;
    unique case (state_q)
      dpds_pkg::DPDS_RUN: ;
      dpds_pkg::DPDS_SYNC: sync_hold = 1'b1;
      dpds_pkg::DPDS_SLEEP: halt = 1'b1;
      dpds_pkg::DPDS_HRESET: halt = 1'b1;
      default: halt = 1'b1;
    endcase
  end

  // --------------------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------------------

  logic [7:0] rd_mux;

  // reads answer in every state, sleep included
  always_comb begin
    rd_mux = 8'h00;
    if (is_phase(reg_addr)) begin
      rd_mux = phase_q[div_index(reg_addr)];
    end else if (is_div(reg_addr)) begin
      rd_mux = div_cfg_q[div_index(reg_addr)];
    end else if (is_outctl(reg_addr)) begin
      rd_mux = outctl_q[out_index(reg_addr)];
    end else begin
      unique case (reg_addr)
        `DPDS_RAMP_A: rd_mux = ramp_a_q;
        `DPDS_FINE_A: rd_mux = fine_a_q;
        `DPDS_RAMP_B: rd_mux = ramp_b_q;
        `DPDS_FINE_B: rd_mux = fine_b_q;
        `DPDS_FUNC: rd_mux = {asleep, pin_mode_q, 2'h0, soft_sync_q, 2'h0};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------------------
  // dividers and delay paths
  // --------------------------------------------------------------------------

  for (genvar g = 0; g < 8; g++) begin : g_div
    dpds_divider u_div (
      .clock(clock),
      .resetn(resetn),
      .halt(halt),
      .sync_hold(sync_hold),
      .div_cfg(div_cfg_q[g]),
      .phase(phase_q[g]),
      .clk_out(clk_out[g])
    );
  end

  // settings stay live in sleep so a wake needs no rewrite
  dpds_delay_calc u_delay_a (
    .clock(clock),
    .resetn(resetn),
    .ramp_byte(ramp_a_q),
    .fine_byte(fine_a_q),
    .settings(delayed_output_a_cfg)
  );

  dpds_delay_calc u_delay_b (
    .clock(clock),
    .resetn(resetn),
    .ramp_byte(ramp_b_q),
    .fine_byte(fine_b_q),
    .settings(delayed_output_b_cfg)
  );

  // --------------------------------------------------------------------------
  // output stage control
  // --------------------------------------------------------------------------

  // enables gated by sleep; the LVPECL four go to safe off instead of floating
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_enable <= 8'h00;
      out_cmos_sel <= 4'h0;
      lvpecl_safe_off <= 4'h0;
      pll_powerdown <= 1'b0;
      asleep <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        out_enable[i] <= ~outctl_q[i][`DPDS_OUT_OFF_BIT] && !halt;
      end
      for (int i = 0; i < 4; i++) begin
        out_cmos_sel[i] <= outctl_q[i+4][`DPDS_OUT_CMOS_BIT];
        lvpecl_safe_off[i] <= halt;
      end
      pll_powerdown <= (state_d == dpds_pkg::DPDS_SLEEP);
      asleep <= (state_q == dpds_pkg::DPDS_SLEEP);
    end
  end

endmodule : dpds_top

//--- verification/dpds_top_checker.sv
// assertions on the ports of the output clock control block
`timescale 1ns/1ps
module dpds_top_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic function_pin,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [7:0] clk_out,
  input wire logic [7:0] out_enable,
  input wire logic [3:0] lvpecl_safe_off,
  input wire logic pll_powerdown,
  input wire logic asleep,
  input wire dpds_pkg::dpds_delay_s delayed_output_a_cfg,
  input wire dpds_pkg::dpds_delay_s delayed_output_b_cfg
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ----------
  // register port
  // ----------
  read_answer_a: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read not answered in the next cycle");
  answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd_en))
    else $error("read answer without a read");
  // a pin hard reset leaves the read data alone; judged only with the pin high
  rdata_hold_a: assert property (function_pin && !reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without an answer");
  // ----------
  // sleep
  // ----------
  // entry latency of the outputs is not judged, only the settled state
  sleep_quiet_a: assert property (asleep && $past(asleep) |->
    out_enable == 8'h00 && clk_out == 8'h00 && lvpecl_safe_off == 4'hF)
    else $error("outputs not quiet in sleep");
  pll_stop_a: assert property ($rose(asleep) |-> pll_powerdown)
    else $error("pll running on sleep entry");
  wake_pin_a: assert property (function_pin [*7] |-> !asleep)
    else $error("asleep with the pin held high");
  // ----------
  // delay decode, two cycles behind the write
  // ----------
  ramp_decode_a: assert property (
    function_pin [*5] ##0 (reg_wr_en && reg_addr == 8'h35) |-> ##2
    delayed_output_a_cfg.ramp_ua == 11'h0C8 * ({8'h00, $past(reg_wdata[2:0], 2)} + 11'h001))
    else $error("ramp current decode wrong");
  caps_decode_a: assert property (
    function_pin [*5] ##0 (reg_wr_en && reg_addr == 8'h39) |-> ##2
    delayed_output_b_cfg.caps == 3'($countones(~$past(reg_wdata[5:3], 2)) + 1))
    else $error("capacitor count decode wrong");
  fine_decode_a: assert property (
    function_pin [*5] ##0 (reg_wr_en && reg_addr == 8'h36) |-> ##2
    delayed_output_a_cfg.fine == $past(reg_wdata[5:1], 2))
    else $error("fine code decode wrong");
endmodule : dpds_top_checker

bind dpds_top dpds_top_checker dpds_top_checker_i (.clock, .resetn, .function_pin, .reg_wr_en,
  .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .clk_out, .out_enable,
  .lvpecl_safe_off, .pll_powerdown, .asleep, .delayed_output_a_cfg, .delayed_output_b_cfg);

//--- verification/dpds_clock_sink.sv
// receiver model: times the first edge of each output and counts rising edges
`timescale 1ns/1ps
module dpds_clock_sink (
  input wire logic clock,
  input wire logic arm,
  input wire logic [7:0] clk_out,
  output int first_edge [8],
  output int rise_count
);
  logic [7:0] ref_q;
  logic [7:0] seen_q;
  logic [7:0] prev_q = 8'h00;
  int cyc_q;
  int rise_q = 0;
  // level at arm is the reference; the first departure from it is the first edge
  always @(posedge clock) begin
    if (!arm) begin
      ref_q <= clk_out;
      seen_q <= 8'h00;
      cyc_q <= 0;
      // a stale time from an earlier run must not stand in for a stuck divider
      for (int i = 0; i < 8; i++) begin
        first_edge[i] <= -1;
      end
    end else begin
      cyc_q <= cyc_q + 1;
      for (int i = 0; i < 8; i++) begin
        if (!seen_q[i] && clk_out[i] !== ref_q[i]) begin
          seen_q[i] <= 1'b1;
          first_edge[i] <= cyc_q;
        end
      end
    end
  end
  // rising edges on all outputs, to see that halted dividers stay halted
  always @(posedge clock) begin
    prev_q <= clk_out;
    rise_q <= rise_q + $countones(clk_out & ~prev_q);
  end
  assign rise_count = rise_q;
endmodule : dpds_clock_sink

//--- verification/tb_dpds_top.sv
// self-checking bench for the output clock control block
`timescale 1ns/1ps
`include "dpds_cfg.svh"
module tb_dpds_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic function_pin = 1'b1;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [7:0] clk_out;
  logic [7:0] out_enable;
  logic [3:0] out_cmos_sel;
  logic [3:0] lvpecl_safe_off;
  logic pll_powerdown;
  logic asleep;
  dpds_pkg::dpds_delay_s cfg_a;
  dpds_pkg::dpds_delay_s cfg_b;
  logic arm = 1'b0;
  int first_edge [8];
  int rise_count;
  int bad_count = 0;
  int check_count = 0;
  int rc;
  logic [7:0] rd_q;
  // offsets 0..4 (4 wraps onto 0 at divide by four), start-high cases, largest plain offset
  logic [7:0] phase_byte [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h11, 8'h0F};

  always #2.5 clock = ~clock;

  dpds_top dpds_top_i (.clock, .resetn, .function_pin, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .clk_out, .out_enable, .out_cmos_sel,
    .lvpecl_safe_off, .pll_powerdown, .asleep, .delayed_output_a_cfg(cfg_a),
    .delayed_output_b_cfg(cfg_b));
  dpds_clock_sink dpds_clock_sink_i (.clock, .arm, .clk_out, .first_edge, .rise_count);

  // ----------
  // tasks
  // ----------
  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  task automatic chk_cfg(input string name, input dpds_pkg::dpds_delay_s exp,
      input dpds_pkg::dpds_delay_s got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_cfg

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask : wr

  // the answer arrives one cycle after the strobe; a missing one ends the run
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      @(negedge clock);
      if (reg_rvalid === 1'b1) begin
        chk_byte(name, exp, reg_rdata);
        return;
      end
    end
    bad_count++;
    give_verdict();
  endtask : rdchk

  task automatic wait_sleep(input logic want);
    for (int n = 0; n < 20; n++) begin
      @(negedge clock);
      if (asleep === want) begin
        return;
      end
    end
    bad_count++;
    give_verdict();
  endtask : wait_sleep

  // pulse the pin low, then compare each divider's first edge with divider 0
  task automatic do_sync();
    @(posedge clock);
    function_pin <= 1'b0;
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk_byte("hold level", 8'h60, clk_out);
    @(posedge clock);
    function_pin <= 1'b1;
    arm <= 1'b1;
    repeat (60) @(posedge clock);
    @(negedge clock);
    for (int i = 1; i < 8; i++) begin
      chk_byte("lag", {3'h0, phase_byte[i][4:0]}, 8'(first_edge[i] - first_edge[0]));
    end
    chk_byte("wrapped phase", {7'h00, clk_out[0]}, {7'h00, clk_out[4]});
    @(posedge clock);
    arm <= 1'b0;
  endtask : do_sync

  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    rdchk(`DPDS_PHASE_FIRST, 8'h00, "phase reset");
    rdchk(`DPDS_RAMP_A, 8'h00, "ramp reset");
    wr(8'h37, 8'hFF);
    rdchk(8'h37, 8'h00, "unmapped");
    wr(`DPDS_DELAY_FIRST, 8'hFF);
    rdchk(`DPDS_DELAY_FIRST, 8'h00, "unmapped");
    // every ramp and capacitor code; fine codes step by nine from 0, wrapping at 32, ending on 31
    for (int c = 0; c < 8; c++) begin
      wr(`DPDS_RAMP_A, {2'h3, 3'(c), 3'(c)});
      wr(`DPDS_FINE_A, {2'h3, 5'(c * 9), 1'b1});
      wr(`DPDS_RAMP_B, {2'h0, 3'(7 - c), 3'(c)});
      rdchk(`DPDS_FINE_A, {2'h0, 5'(c * 9), 1'b0}, "fine byte");
      chk_cfg("delay a", {11'h0C8 * 11'(c + 1), 3'h4 - 3'($countones(3'(c))), 5'(c * 9)}, cfg_a);
      chk_cfg("delay b", {11'h0C8 * 11'(c + 1), 3'($countones(3'(c)) + 1), 5'h00}, cfg_b);
    end
    rdchk(`DPDS_RAMP_A, 8'h3F, "ramp byte");
    wr(`DPDS_FINE_B, 8'hFF);
    rdchk(`DPDS_FINE_B, 8'h3E, "fine byte b");
    // all dividers at divide by four, reserved phase bits written high
    for (int i = 0; i < 8; i++) begin
      wr(8'(`DPDS_DIV_FIRST + 2 * i), 8'h11);
      wr(8'(`DPDS_PHASE_FIRST + 2 * i), phase_byte[i] | 8'hE0);
      rdchk(8'(`DPDS_PHASE_FIRST + 2 * i), phase_byte[i], "phase byte");
    end
    wr(`DPDS_FUNC, 8'h20);
    do_sync();
    wr(8'h3D, 8'h01);
    wr(8'h41, 8'h02);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk_byte("enables", 8'hFD, out_enable);
    chk_byte("cmos select", 8'h02, {4'h0, out_cmos_sel});
    chk_byte("safe off", 8'h00, {4'h0, lvpecl_safe_off});
    // sleep: register port stays alive, dividers stop
    wr(`DPDS_FUNC, 8'h40);
    @(posedge clock);
    function_pin <= 1'b0;
    wait_sleep(1'b1);
    repeat (2) @(negedge clock);
    chk_byte("sleep enables", 8'h00, out_enable);
    chk_byte("sleep safe off", 8'h0F, {4'h0, lvpecl_safe_off});
    chk_byte("sleep pll", 8'h01, {7'h00, pll_powerdown});
    rc = rise_count;
    rdchk(`DPDS_FUNC, 8'hC0, "asleep flag");
    wr(`DPDS_PHASE_FIRST, 8'h05);
    rdchk(`DPDS_PHASE_FIRST, 8'h05, "sleep write");
    repeat (20) @(posedge clock);
    chk_byte("sleep edges", 8'h00, 8'(rise_count - rc));
    @(posedge clock);
    function_pin <= 1'b1;
    wait_sleep(1'b0);
    repeat (3) @(negedge clock);
    chk_byte("wake enables", 8'hFD, out_enable);
    rdchk(`DPDS_PHASE_FIRST, 8'h05, "wake phase");
    // outputs no longer aligned after wake, so sync again
    wr(`DPDS_PHASE_FIRST, 8'h00);
    wr(8'h3D, 8'h00);
    wr(`DPDS_FUNC, 8'h20);
    do_sync();
    // soft sync bit with no pin function: dividers held at their start levels
    wr(`DPDS_FUNC, 8'h64);
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk_byte("soft hold", 8'h60, clk_out);
    // hard reset through the pin drops writes and restores defaults
    wr(`DPDS_FUNC, 8'h00);
    @(posedge clock);
    function_pin <= 1'b0;
    repeat (8) @(posedge clock);
    wr(8'h4B, 8'h0A);
    @(posedge clock);
    function_pin <= 1'b1;
    repeat (8) @(posedge clock);
    rdchk(8'h4B, 8'h00, "reset phase");
    rdchk(`DPDS_RAMP_A, 8'h00, "reset ramp");
    rdchk(8'h41, 8'h00, "reset outctl");
    give_verdict();
  end
endmodule : tb_dpds_top
